// ### hdl/iolm_pkg.sv
// package with constants and types of the io line function selector
package iolm_pkg;

  localparam int NUM_LINES = 4;

  // parameter addresses of the selection registers and the level status
  localparam logic [15:0] REG_LINE1_SEL = 16'h0722;
  localparam logic [15:0] REG_LINE2_SEL = 16'h0724;
  localparam logic [15:0] REG_LINE3_SEL = 16'h0726;
  localparam logic [15:0] REG_LINE4_SEL = 16'h0728;
  localparam logic [15:0] REG_LINE_LEVELS = 16'h0730;

  // selection codes
  localparam logic [15:0] FN_FREE_IN = 16'h0001;
  localparam logic [15:0] FN_FAULT_CLR = 16'h0002;
  localparam logic [15:0] FN_ENABLE = 16'h0003;
  localparam logic [15:0] FN_HALT = 16'h0004;
  localparam logic [15:0] FN_JOG_POS = 16'h0009;
  localparam logic [15:0] FN_JOG_NEG = 16'h000a;
  localparam logic [15:0] FN_JOG_FAST = 16'h000b;
  localparam logic [15:0] FN_HOME = 16'h0014;
  localparam logic [15:0] FN_UPPER_STOP = 16'h0015;
  localparam logic [15:0] FN_LOWER_STOP = 16'h0016;
  localparam logic [15:0] FN_FREE_OUT = 16'h0065;
  localparam logic [15:0] FN_NO_FAULT = 16'h0066;
  localparam logic [15:0] FN_READY = 16'h0067;

  // factory selections, element 0 is the first line
  localparam logic [3:0][15:0] FACTORY_SEL = {FN_HOME, FN_FREE_IN, FN_LOWER_STOP, FN_UPPER_STOP};

  // last step of the power-up load from the persistent store
  localparam logic [2:0] LOAD_LAST = 3'h4;

  typedef enum logic [1:0] {ST_LOAD, ST_IDLE, ST_ACC} iolm_state_t;

  // parameter access request and answer
  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } iolm_preq_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [15:0] rdata;
  } iolm_prsp_t;

  // drive status seen by the selector
  typedef struct packed {
    logic power_stage_on;
    logic local_control;
    logic no_fault;
    logic drive_ready;
  } iolm_drv_t;

  // drive functions fed from the lines
  typedef struct packed {
    logic fault_clear;
    logic enable;
    logic halt;
    logic jog_pos;
    logic jog_neg;
    logic jog_fast;
    logic home_switch;
    logic upper_travel_stop;
    logic lower_travel_stop;
  } iolm_func_t;

  // persistent store state
  typedef struct packed {
    logic [3:0][15:0] mem;
    logic [15:0] rdata;
  } iolm_store_t;

  // selector core state
  typedef struct packed {
    iolm_state_t st;
    logic [2:0] cnt;
    logic preq_we;
    logic [15:0] preq_addr;
    logic [15:0] preq_wdata;
    logic [3:0][15:0] sel;
    logic [3:0] sync1;
    logic [3:0] sync2;
    iolm_prsp_t rsp;
    logic [3:0] line_out;
    logic [3:0] line_oe_n;
    iolm_func_t func;
  } iolm_core_t;

endpackage : iolm_pkg

// ### hdl/iolm_store.sv
// persistent selection store with registered read port
`timescale 1ns/1ps
`default_nettype none

module iolm_store (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic restore_factory,
  input wire logic wr_en,
  input wire logic [1:0] wr_idx,
  input wire logic [15:0] wr_data,
  input wire logic [1:0] rd_idx,
  output logic [15:0] rd_data
);

  iolm_pkg::iolm_store_t st_ff;
  iolm_pkg::iolm_store_t nxt_st;

  // the array is kept over reset on purpose: it models non-volatile memory
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rdata = st_ff.mem[rd_idx];
    if (restore_factory) begin
      nxt_st.mem = iolm_pkg::FACTORY_SEL;
    end else if (wr_en) begin
      nxt_st.mem[wr_idx] = wr_data;
    end
    if (!nrst) begin
      nxt_st.rdata = 16'h0000;
    end
  end

  always_ff @(posedge sys_clk) begin
    st_ff <= nxt_st;
  end

  assign rd_data = st_ff.rdata;

endmodule : iolm_store

`default_nettype wire

// ### hdl/iolm_mux.sv
// function selector for the four local digital lines
// Summary of operation
// RULE1 - code 1 makes a line a plain input with no drive function
// RULE2 - code 2 is fault clear, code 3 enable, both only under local control
// RULE3 - code 4 makes the line a halt request input
// RULE4 - codes 9, 10, 11 are jog positive, jog negative and jog fast/slow inputs
// RULE5 - code 20, homing switch, is accepted on all four lines
// RULE6 - code 21, upper travel stop, is accepted only on line one
// RULE7 - code 22, lower travel stop, is accepted only on line two
// RULE8 - lines three and four take only common and output codes, no travel stops
// RULE9 - codes 101, 102, 103 make outputs: free, no fault, ready
// RULE10 - selection writes are taken only while the power stage is off
// RULE11 - new selection is stored but acts only after the next power-up
// RULE12 - factory: upper stop, lower stop, free input, homing switch
// RULE13 - levels of free input lines are readable in a status parameter
// RULE14 - a code not allowed for that line is refused, old value kept
`timescale 1ns/1ps
`default_nettype none

module iolm_mux (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic restore_factory,
  input wire iolm_pkg::iolm_preq_t preq,
  output logic preq_ready,
  output iolm_pkg::iolm_prsp_t prsp,
  input wire iolm_pkg::iolm_drv_t drv,
  input wire logic [3:0] free_out_value,
  input wire logic [3:0] line_in,
  output logic [3:0] line_out,
  output logic [3:0] line_oe_n,
  output iolm_pkg::iolm_func_t func,
  output logic [3:0] line_actual_levels
);

  iolm_pkg::iolm_core_t st_ff;
  iolm_pkg::iolm_core_t nxt_st;
  logic st_wr_en;
  logic [1:0] st_wr_idx;
  logic [1:0] st_rd_idx;
  logic [15:0] st_rd_data;

  // selection code allowed on line idx (0 is line one)
  function automatic logic code_legal(input logic [1:0] idx, input logic [15:0] code);
    logic ok;
    ok = 1'b0;
    if (code == iolm_pkg::FN_FREE_IN || code == iolm_pkg::FN_FAULT_CLR ||
        code == iolm_pkg::FN_ENABLE || code == iolm_pkg::FN_HALT) begin
      ok = 1'b1; // see RULE1 see RULE2 see RULE3
    end else if (code == iolm_pkg::FN_JOG_POS || code == iolm_pkg::FN_JOG_NEG ||
                 code == iolm_pkg::FN_JOG_FAST) begin
      ok = 1'b1; // see RULE4
    end else if (code == iolm_pkg::FN_HOME) begin
      ok = 1'b1; // see RULE5
    end else if (code == iolm_pkg::FN_UPPER_STOP) begin
      ok = (idx == 2'h0); // see RULE6 see RULE8
    end else if (code == iolm_pkg::FN_LOWER_STOP) begin
      ok = (idx == 2'h1); // see RULE7 see RULE8
    end else if (code == iolm_pkg::FN_FREE_OUT || code == iolm_pkg::FN_NO_FAULT ||
                 code == iolm_pkg::FN_READY) begin
      ok = 1'b1; // see RULE9
    end
    return ok;
  endfunction : code_legal

  // selection register address to line index, hit flag in the top bit
  function automatic logic [2:0] addr_line(input logic [15:0] addr);
    logic [2:0] res;
    res = 3'h0;
    if (addr == iolm_pkg::REG_LINE1_SEL) begin
      res = 3'h4;
    end else if (addr == iolm_pkg::REG_LINE2_SEL) begin
      res = 3'h5;
    end else if (addr == iolm_pkg::REG_LINE3_SEL) begin
      res = 3'h6;
    end else if (addr == iolm_pkg::REG_LINE4_SEL) begin
      res = 3'h7;
    end
    return res;
  endfunction : addr_line

  // line is driven by the device for output codes
  function automatic logic is_output(input logic [15:0] code);
    return code == iolm_pkg::FN_FREE_OUT || code == iolm_pkg::FN_NO_FAULT ||
           code == iolm_pkg::FN_READY;
  endfunction : is_output

  // legality is judged here, so the store stays a plain word array
  iolm_store u_store (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .restore_factory(restore_factory),
    .wr_en(st_wr_en),
    .wr_idx(st_wr_idx),
    .wr_data(st_ff.preq_wdata),
    .rd_idx(st_rd_idx),
    .rd_data(st_rd_data)
  );

  // store port: loader walks the lines, otherwise the pending request line is read
  // the read starts in the taking cycle, so the answer needs no extra wait state
  always_comb begin
    logic [2:0] hit;
    logic [2:0] req_hit;
    hit = addr_line(st_ff.preq_addr);
    req_hit = addr_line(preq.addr);
    st_rd_idx = (st_ff.st == iolm_pkg::ST_LOAD) ? st_ff.cnt[1:0] : req_hit[1:0];
    st_wr_idx = hit[1:0];
    st_wr_en = 1'b0;
    if (st_ff.st == iolm_pkg::ST_ACC && st_ff.preq_we && hit[2] && !drv.power_stage_on &&
        code_legal(hit[1:0], st_ff.preq_wdata)) begin
      st_wr_en = 1'b1; // see RULE10 see RULE14 see RULE11
    end
  end

  // next state of the whole selector
  always_comb begin
    logic [2:0] hit;
    logic [3:0] lvl;
    nxt_st = st_ff;
    hit = addr_line(st_ff.preq_addr);
    lvl = st_ff.sync2;
    // pins are asynchronous: two flip-flops before any logic reads them
    nxt_st.sync1 = line_in;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.rsp.ack = 1'b0;
    case (st_ff.st)
      iolm_pkg::ST_LOAD: begin
        // active selections only change here, right after reset
        // one spare step, because the store read port is registered
        if (st_ff.cnt != 3'h0) begin
          nxt_st.sel[st_ff.cnt[1:0] - 2'h1] = st_rd_data; // see RULE11
        end
        nxt_st.cnt = st_ff.cnt + 3'h1;
        if (st_ff.cnt == iolm_pkg::LOAD_LAST) begin
          nxt_st.st = iolm_pkg::ST_IDLE;
        end
      end
      iolm_pkg::ST_IDLE: begin
        if (preq.req) begin
          nxt_st.preq_we = preq.we;
          nxt_st.preq_addr = preq.addr;
          nxt_st.preq_wdata = preq.wdata;
          nxt_st.st = iolm_pkg::ST_ACC;
        end
      end
      iolm_pkg::ST_ACC: begin
        nxt_st.rsp.ack = 1'b1;
        nxt_st.rsp.err = 1'b0;
        nxt_st.rsp.rdata = 16'h0000;
        if (st_ff.preq_addr == iolm_pkg::REG_LINE_LEVELS) begin
          nxt_st.rsp.err = st_ff.preq_we;
          nxt_st.rsp.rdata = {12'h000, lvl}; // see RULE13
        end else if (!hit[2]) begin
          nxt_st.rsp.err = 1'b1;
        end else if (st_ff.preq_we) begin
          // refused writes leave the stored selection untouched
          nxt_st.rsp.err = drv.power_stage_on || !code_legal(hit[1:0], st_ff.preq_wdata); // see RULE10 see RULE14
        end else begin
          nxt_st.rsp.rdata = st_rd_data; // reads show the stored, not the active, value
        end
        nxt_st.st = iolm_pkg::ST_IDLE;
      end
      default: begin
        nxt_st.st = iolm_pkg::ST_IDLE;
      end
    endcase
    // line functions follow the active selections
    // several lines on one code are ored, so either of them acts
    nxt_st.func = '0;
    for (int i = 0; i < iolm_pkg::NUM_LINES; i++) begin
      nxt_st.line_oe_n[i] = !is_output(st_ff.sel[i]);
      nxt_st.line_out[i] = 1'b0;
      case (st_ff.sel[i])
        iolm_pkg::FN_FAULT_CLR: nxt_st.func.fault_clear |= lvl[i] & drv.local_control; // see RULE2
        iolm_pkg::FN_ENABLE: nxt_st.func.enable |= lvl[i] & drv.local_control; // see RULE2
        iolm_pkg::FN_HALT: nxt_st.func.halt |= lvl[i]; // see RULE3
        iolm_pkg::FN_JOG_POS: nxt_st.func.jog_pos |= lvl[i]; // see RULE4
        iolm_pkg::FN_JOG_NEG: nxt_st.func.jog_neg |= lvl[i]; // see RULE4
        iolm_pkg::FN_JOG_FAST: nxt_st.func.jog_fast |= lvl[i]; // see RULE4
        iolm_pkg::FN_HOME: nxt_st.func.home_switch |= lvl[i]; // see RULE5
        iolm_pkg::FN_UPPER_STOP: nxt_st.func.upper_travel_stop |= lvl[i]; // see RULE6
        iolm_pkg::FN_LOWER_STOP: nxt_st.func.lower_travel_stop |= lvl[i]; // see RULE7
        iolm_pkg::FN_FREE_OUT: nxt_st.line_out[i] = free_out_value[i]; // see RULE9
        iolm_pkg::FN_NO_FAULT: nxt_st.line_out[i] = drv.no_fault; // see RULE9
        iolm_pkg::FN_READY: nxt_st.line_out[i] = drv.drive_ready; // see RULE9
        default: begin
          // free input and unknown codes drive nothing into the drive
        end
      endcase
    end
    // synchronous reset: lines released, factory set until the load finishes
    if (!nrst) begin
      nxt_st = '0;
      nxt_st.st = iolm_pkg::ST_LOAD;
      nxt_st.sel = iolm_pkg::FACTORY_SEL; // see RULE12
      nxt_st.line_oe_n = 4'hf;
    end
  end

  // one register stage for all state keeps prsp, line_out, line_oe_n and func straight from flops
  always_ff @(posedge sys_clk) begin
    st_ff <= nxt_st;
  end

  // levels of lines set to free input, others read zero
  always_comb begin
    for (int i = 0; i < iolm_pkg::NUM_LINES; i++) begin
      line_actual_levels[i] = st_ff.sync2[i] && st_ff.sel[i] == iolm_pkg::FN_FREE_IN; // see RULE13
    end
  end

  // ready is combinational, so a request can be taken while the answer shows
  assign preq_ready = (st_ff.st == iolm_pkg::ST_IDLE);
  assign prsp = st_ff.rsp;
  assign line_out = st_ff.line_out;
  assign line_oe_n = st_ff.line_oe_n;
  assign func = st_ff.func;

endmodule : iolm_mux

`default_nettype wire

// ### tb/iolm_mux_asserts.sv
// assertion checker for the io line function selector
`timescale 1ns/1ps
`default_nettype none

module iolm_mux_asserts (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic restore_factory,
  input wire iolm_pkg::iolm_preq_t preq,
  input wire logic preq_ready,
  input wire iolm_pkg::iolm_prsp_t prsp,
  input wire iolm_pkg::iolm_drv_t drv,
  input wire logic [3:0] free_out_value,
  input wire logic [3:0] line_in,
  input wire logic [3:0] line_out,
  input wire logic [3:0] line_oe_n,
  input wire iolm_pkg::iolm_func_t func,
  input wire logic [3:0] line_actual_levels
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // a request counts once the selector takes it
  wire logic tk = preq.req && preq_ready;
  wire logic tw = tk && preq.we;
  logic [3:0] since_ff;

  // cycles since reset release, saturating; line directions may only change during the load
  always_ff @(posedge sys_clk) begin
    if (!nrst) since_ff <= 4'h0;
    else if (since_ff != 4'hf) since_ff <= since_ff + 4'h1;
  end

  AST_ACK_LAT: assert property (tk |=> !preq_ready ##1 prsp.ack)
    else $error("answer not two cycles after take");
  AST_ACK_PULSE: assert property (prsp.ack |=> !prsp.ack)
    else $error("answer pulse too long");
  AST_PWR_REFUSE: assert property (tw ##1 drv.power_stage_on |=> prsp.ack && prsp.err)
    else $error("write taken with power stage on");
  AST_UPPER_ONLY1: assert property (tw && preq.wdata == 16'h0015 && preq.addr != 16'h0722
    |-> ##2 prsp.err)
    else $error("upper stop taken off line one");
  AST_LOWER_ONLY2: assert property (tw && preq.wdata == 16'h0016 && preq.addr != 16'h0724
    |-> ##2 prsp.err)
    else $error("lower stop taken off line two");
  AST_BAD_CODE: assert property (tw && preq.wdata == 16'h0007 |-> ##2 prsp.err)
    else $error("unknown code taken");
  AST_HOME_OK: assert property (tw && preq.wdata == 16'h0014 && preq.addr[15:4] == 12'h072
    && preq.addr[3:0] inside {4'h2, 4'h4, 4'h6, 4'h8} ##1 !drv.power_stage_on
    |=> !prsp.err)
    else $error("homing code refused");
  AST_LVL_INPUT: assert property (!(|(line_actual_levels & ~line_oe_n)))
    else $error("level shown for a driven line");
  AST_OE_STABLE: assert property ($changed(line_oe_n) |-> since_ff < 4'ha)
    else $error("line direction changed without power cycle");

  COV_REFUSE: cover property (tw ##2 prsp.err);
  COV_ENABLE: cover property ($rose(func.enable));
  COV_DRIVE4: cover property (!line_oe_n[3]);
endmodule : iolm_mux_asserts

bind iolm_mux iolm_mux_asserts chk (.sys_clk, .nrst, .restore_factory, .preq, .preq_ready,
  .prsp, .drv, .free_out_value, .line_in, .line_out, .line_oe_n, .func, .line_actual_levels);

`default_nettype wire

// ### tb/iolm_lines_model.sv
// external switches and loads sitting on the four local lines
`timescale 1ns/1ps
`default_nettype none

module iolm_lines_model (
  input wire logic [3:0] sw_level,
  input wire logic [3:0] line_out,
  input wire logic [3:0] line_oe_n,
  output logic [3:0] line_in
);
  // a driven line shows the device level, a released one its switch
  assign line_in = (line_oe_n & sw_level) | (~line_oe_n & line_out);
endmodule : iolm_lines_model

`default_nettype wire

// ### tb/test_iolm_mux.sv
// self-checking bench for the io line function selector
`timescale 1ns/1ps
`default_nettype none

module test_iolm_mux;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic restore_factory = 1'b1;
  iolm_pkg::iolm_preq_t preq = '0;
  iolm_pkg::iolm_drv_t drv = '0;
  logic [3:0] fov = 4'h0;
  logic [3:0] sw = 4'h0;
  logic rdy;
  iolm_pkg::iolm_prsp_t prsp;
  logic [3:0] lin;
  logic [3:0] lout;
  logic [3:0] loe_n;
  iolm_pkg::iolm_func_t func;
  logic [3:0] lvl;
  logic [16:0] r;
  int fail_count = 0;
  int compares = 0;
  int cyc = 0;

  // free running clock
  always #5 sys_clk = ~sys_clk;

  iolm_mux dut (.sys_clk(sys_clk), .nrst(nrst), .restore_factory(restore_factory),
    .preq(preq), .preq_ready(rdy), .prsp(prsp), .drv(drv), .free_out_value(fov),
    .line_in(lin), .line_out(lout), .line_oe_n(loe_n), .func(func), .line_actual_levels(lvl));
  iolm_lines_model sw_model (.sw_level(sw), .line_out(lout), .line_oe_n(loe_n), .line_in(lin));

  // hang guard, the whole run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      results();
    end
  end

  task results;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results

  task chk(input string n, input logic [16:0] e, input logic [16:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // reset stands in for a power cycle; the store survives it
  task boot;
    @(negedge sys_clk);
    nrst = 1'b0;
    repeat (16) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (8) @(negedge sys_clk);
  endtask : boot

  // request held until taken, answer awaited under a bounded count
  task acc(input logic we, input logic [15:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(negedge sys_clk);
    preq = '{1'b1, we, a, d};
    while (rdy !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    @(negedge sys_clk);
    preq.req = 1'b0;
    while (prsp.ack !== 1'b1 && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    r = {prsp.err, prsp.rdata};
  endtask : acc

  task wchk(input logic [15:0] a, input logic [15:0] d, input logic e);
    acc(1'b1, a, d);
    chk("write refusal", {16'h0, e}, {16'h0, r[16]});
  endtask : wchk

  // writes are pending until the next power cycle
  task cfg(input logic [3:0][15:0] c);
    logic [3:0] o;
    o = loe_n;
    for (int i = 0; i < 4; i++) wchk(16'h0722 + 16'(2 * i), c[i], 1'b0);
    chk("direction before power cycle", {13'h0, o}, {13'h0, loe_n});
    boot();
  endtask : cfg

  task t_factory;
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, 16'h0722 + 16'(2 * i), 16'h0);
      chk("factory code", {1'b0, iolm_pkg::FACTORY_SEL[i]}, r);
    end
    sw = 4'h9;
    repeat (4) @(negedge sys_clk);
    chk("factory functions", 17'h00006, {8'h0, func});
    $display("test factory done");
  endtask : t_factory

  task t_refuse;
    drv.power_stage_on = 1'b1;
    wchk(16'h0726, iolm_pkg::FN_HALT, 1'b1);
    drv.power_stage_on = 1'b0;
    wchk(16'h0726, iolm_pkg::FN_UPPER_STOP, 1'b1);
    wchk(16'h0728, iolm_pkg::FN_LOWER_STOP, 1'b1);
    wchk(16'h0724, iolm_pkg::FN_UPPER_STOP, 1'b1);
    wchk(16'h0722, iolm_pkg::FN_LOWER_STOP, 1'b1);
    wchk(16'h0728, 16'h0007, 1'b1);
    wchk(16'h0730, iolm_pkg::FN_FREE_IN, 1'b1);
    acc(1'b0, 16'h0726, 16'h0);
    chk("kept code", 17'h00001, r);
    acc(1'b0, 16'h0700, 16'h0);
    chk("unmapped read", 17'h10000, r);
    $display("test refusals done");
  endtask : t_refuse

  task t_outputs;
    cfg({iolm_pkg::FN_NO_FAULT, iolm_pkg::FN_FREE_IN, iolm_pkg::FN_FAULT_CLR,
      iolm_pkg::FN_FREE_OUT});
    drv.no_fault = 1'b1;
    drv.local_control = 1'b1;
    fov = 4'h1;
    sw = 4'h6;
    repeat (4) @(negedge sys_clk);
    chk("direction", 17'h00006, {13'h0, loe_n});
    chk("driven levels", 17'h00009, {13'h0, lout & ~loe_n});
    chk("free input level", 17'h00004, {13'h0, lvl});
    acc(1'b0, 16'h0730, 16'h0);
    chk("level register", 17'h00004, r & 17'h10004);
    chk("fault clear", 17'h00100, {8'h0, func});
    drv.local_control = 1'b0;
    fov = 4'h0;
    repeat (4) @(negedge sys_clk);
    chk("remote fault clear", 17'h00000, {8'h0, func});
    chk("free out low", 17'h00008, {13'h0, lout & ~loe_n});
    $display("test outputs done");
  endtask : t_outputs

  task t_inputs;
    cfg({iolm_pkg::FN_JOG_FAST, iolm_pkg::FN_JOG_NEG, iolm_pkg::FN_JOG_POS,
      iolm_pkg::FN_HALT});
    sw = 4'hf;
    repeat (4) @(negedge sys_clk);
    chk("halt and jog", 17'h00078, {8'h0, func});
    chk("no free level", 17'h00000, {13'h0, lvl});
    cfg({iolm_pkg::FN_READY, iolm_pkg::FN_HOME, iolm_pkg::FN_LOWER_STOP,
      iolm_pkg::FN_ENABLE});
    drv.local_control = 1'b1;
    drv.drive_ready = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk("enable home lower", 17'h00085, {8'h0, func});
    chk("ready out", 17'h00008, {13'h0, lout & ~loe_n});
    $display("test inputs done");
  endtask : t_inputs

  // store is loaded with factory codes once, then a first power-up
  initial begin
    @(negedge sys_clk);
    restore_factory = 1'b0;
    boot();
    t_factory();
    t_refuse();
    t_outputs();
    t_inputs();
    results();
  end
endmodule : test_iolm_mux

`default_nettype wire
